/* File: verilog/fsvpor_seq.sv */
// flash command sequencer: section verify, once read, phrase program
// assumes software and the flash array share clk; array answers by ack
`timescale 1ns/1ns
module fsvpor_seq #(
    parameter logic [23:0] PF_LO = fsvpor_pkg::PF_LO_DEF,
    parameter logic [23:0] PF_HI = fsvpor_pkg::PF_HI_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] param_index_pointer,
    input wire logic param_wr,
    input wire logic [15:0] param_wdata,
    output logic [15:0] param_rdata,
    input wire logic launch,
    input wire logic access_error_clr,
    input wire logic protection_violation_clr,
    input wire logic [2:0] mode_permits,
    input wire logic clock_divider_loaded,
    input wire logic prot_en,
    input wire logic [17:0] prot_lo,
    input wire logic [17:0] prot_hi,
    output logic command_complete_flag,
    output logic access_error_flag,
    output logic protection_violation_flag,
    output logic [1:0] verify_status_bits,
    output logic pflash_read_invalid,
    output logic flash_req,
    output logic flash_we,
    output logic flash_info_sel,
    output logic [23:0] flash_addr,
    output logic [15:0] flash_wdata,
    input wire logic flash_ack,
    input wire logic [15:0] flash_rdata,
    input wire logic flash_rd_err,
    input wire logic flash_rd_uncorr
);
    fsvpor_pkg::fsvpor_state_e state, next_state;
    logic cdone, next_cdone;
    logic aerr, next_aerr;
    logic pviol, next_pviol;
    logic [1:0] mg, next_mg;
    logic [2:0] launch_idx, next_launch_idx;
    logic [2:0] fidx, next_fidx;
    logic [7:0] cmd, next_cmd;
    logic [23:0] base, next_base;
    logic [15:0] count, next_count;
    logic [3:0][15:0] pdata, next_pdata;
    logic [23:0] cur, next_cur;
    logic [17:0] rem, next_rem;
    logic [1:0] w, next_w;
    logic info_sel, next_info_sel;

    logic mem_we;
    logic [2:0] mem_waddr;
    logic [15:0] mem_wdata;
    logic [2:0] mem_raddr;
    logic [15:0] mem_rdata;
    logic launch_bad;
    logic [24:0] sect_end;

    function automatic logic [1:0] mg_upd(input logic [1:0] m,
                                          input logic any_err,
                                          input logic unc_err,
                                          input logic blank_fail);
        // an uncorrectable error is a read error as well
        mg_upd = {m[1] | any_err | unc_err | blank_fail,
            m[0] | unc_err | blank_fail};
    endfunction : mg_upd

    function automatic logic in_pf(input logic [23:0] a);
        in_pf = (a >= PF_LO) && (a <= PF_HI);
    endfunction : in_pf

    // parameter words are read back by software only while idle
    assign mem_raddr = cdone ? param_index_pointer : fidx;

    fsvpor_param_mem #(
        .WIDTH(fsvpor_pkg::WORD_W),
        .DEPTH(fsvpor_pkg::NUM_PARAMS),
        .AW(fsvpor_pkg::PIDX_W)
    ) u_params (
        .clk(clk),
        .nrst(nrst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    assign param_rdata = mem_rdata;
    assign command_complete_flag = cdone;
    assign access_error_flag = aerr;
    assign protection_violation_flag = pviol;
    assign verify_status_bits = mg;
    assign flash_info_sel = info_sel;
    assign flash_addr = cur;
    assign flash_wdata = pdata[w];
    assign flash_req = (state == fsvpor_pkg::ST_RUN)
        || (state == fsvpor_pkg::ST_VERIFY);
    assign flash_we = (state == fsvpor_pkg::ST_RUN)
        && (cmd == fsvpor_pkg::CMD_PHRASE_PGM);
    // array busy with the once field, plain reads are not served
    assign pflash_read_invalid = !cdone
        && (cmd == fsvpor_pkg::CMD_ONCE_READ); // [RULE15]

    // end of section, one past the last byte
    assign sect_end = {1'b0, base} + {6'h00, count, 3'b000};

    always_comb begin
        launch_bad = 1'b1;
        case (cmd)
            fsvpor_pkg::CMD_SECT_VERIFY: begin
                launch_bad = (launch_idx != fsvpor_pkg::IDX_SECT_VERIFY) // [RULE4]
                    || !mode_permits[fsvpor_pkg::PERMIT_SECT] // [RULE8]
                    || !in_pf(base) // [RULE7]
                    || (base[2:0] != 3'h0) // [RULE5]
                    || (count == 16'h0000)
                    || (sect_end > ({1'b0, PF_HI} + 25'h0000001)); // [RULE6]
            end
            fsvpor_pkg::CMD_ONCE_READ: begin
                launch_bad = (launch_idx != fsvpor_pkg::IDX_ONCE_READ) // [RULE13]
                    || !mode_permits[fsvpor_pkg::PERMIT_ONCE] // [RULE8]
                    || (base[15:0] > fsvpor_pkg::ONCE_MAX_IDX); // [RULE14]
            end
            fsvpor_pkg::CMD_PHRASE_PGM: begin
                launch_bad = (launch_idx != fsvpor_pkg::IDX_PHRASE_PGM) // [RULE19]
                    || !mode_permits[fsvpor_pkg::PERMIT_PGM] // [RULE8]
                    || !clock_divider_loaded // [RULE24]
                    || !in_pf(base) // [RULE7]
                    || (base[2:0] != 3'h0); // [RULE5]
            end
            default: begin
                launch_bad = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        next_cdone = cdone;
        // hardware set below overrides the software clear
        next_aerr = aerr & ~access_error_clr;
        next_pviol = pviol & ~protection_violation_clr;
        next_mg = mg;
        next_launch_idx = launch_idx;
        next_fidx = fidx;
        next_cmd = cmd;
        next_base = base;
        next_count = count;
        next_pdata = pdata;
        next_cur = cur;
        next_rem = rem;
        next_w = w;
        next_info_sel = info_sel;
        mem_we = 1'b0;
        mem_waddr = param_index_pointer;
        mem_wdata = param_wdata;
        case (state)
            fsvpor_pkg::ST_IDLE: begin
                mem_we = param_wr & cdone;
                // a launch with an error flag pending is ignored
                if (launch && cdone && !aerr && !pviol) begin
                    next_cdone = 1'b0; // [RULE1]
                    next_mg = fsvpor_pkg::RST_MG;
                    next_launch_idx = param_index_pointer;
                    next_fidx = 3'h0;
                    next_state = fsvpor_pkg::ST_FETCH;
                end
            end
            fsvpor_pkg::ST_FETCH: begin
                // read data lags the index by one cycle
                next_fidx = fidx + 3'h1;
                case (fidx)
                    3'h1: begin
                        next_cmd = mem_rdata[15:8]; // [RULE2]
                        next_base[23:16] = mem_rdata[7:0];
                    end
                    3'h2: begin
                        next_base[15:0] = mem_rdata;
                    end
                    3'h3: begin
                        next_count = mem_rdata;
                        next_pdata[0] = mem_rdata; // [RULE17]
                    end
                    3'h4: begin
                        next_pdata[1] = mem_rdata;
                    end
                    3'h5: begin
                        next_pdata[2] = mem_rdata;
                    end
                    3'h6: begin
                        next_pdata[3] = mem_rdata;
                        next_state = fsvpor_pkg::ST_CHECK;
                    end
                    default: begin
                        next_fidx = fidx + 3'h1;
                    end
                endcase
            end
            fsvpor_pkg::ST_CHECK: begin
                next_w = 2'h0;
                next_rem = fsvpor_pkg::PHRASE_WORDS;
                next_cur = base;
                next_info_sel = 1'b0;
                if (launch_bad) begin
                    next_aerr = 1'b1;
                    next_state = fsvpor_pkg::ST_DONE;
                end else if (cmd == fsvpor_pkg::CMD_PHRASE_PGM && prot_en
                        && base[17:0] >= prot_lo
                        && base[17:0] <= prot_hi) begin
                    next_pviol = 1'b1; // [RULE20]
                    next_state = fsvpor_pkg::ST_DONE;
                end else begin
                    next_state = fsvpor_pkg::ST_RUN;
                    if (cmd == fsvpor_pkg::CMD_SECT_VERIFY) begin
                        next_rem = {count, 2'b00};
                    end
                    if (cmd == fsvpor_pkg::CMD_ONCE_READ) begin
                        // eight phrases of eight bytes in the info region
                        next_info_sel = 1'b1; // [RULE11]
                        next_cur = {18'h00000, base[2:0], 3'b000};
                    end
                end
            end
            fsvpor_pkg::ST_RUN: begin
                if (flash_ack) begin
                    // word 0 sits at the lowest phrase address
                    next_w = w + 2'h1; // [RULE25]
                    next_cur = cur + fsvpor_pkg::WORD_BYTES;
                    next_rem = rem - 18'h00001;
                    if (cmd == fsvpor_pkg::CMD_SECT_VERIFY) begin
                        next_mg = mg_upd(mg, flash_rd_err, flash_rd_uncorr,
                            flash_rdata != fsvpor_pkg::ERASED_WORD); // [RULE3] [RULE9]
                    end
                    if (cmd == fsvpor_pkg::CMD_ONCE_READ) begin
                        next_mg = mg_upd(mg, flash_rd_err, flash_rd_uncorr,
                            1'b0);
                        mem_we = 1'b1; // [RULE10] [RULE12]
                        mem_waddr = fsvpor_pkg::PW_DATA0 + {1'b0, w};
                        mem_wdata = flash_rdata;
                    end
                    if (rem == 18'h00001) begin
                        next_state = fsvpor_pkg::ST_DONE;
                        if (cmd == fsvpor_pkg::CMD_PHRASE_PGM) begin
                            next_state = fsvpor_pkg::ST_VERIFY; // [RULE18]
                            next_cur = base;
                            next_rem = fsvpor_pkg::PHRASE_WORDS;
                        end
                    end
                end
            end
            fsvpor_pkg::ST_VERIFY: begin
                if (flash_ack) begin
                    // a mismatch counts as a readback error
                    next_mg = mg_upd(mg,
                        flash_rd_err || (flash_rdata != pdata[w]),
                        flash_rd_uncorr, 1'b0); // [RULE21]
                    next_w = w + 2'h1;
                    next_cur = cur + fsvpor_pkg::WORD_BYTES;
                    next_rem = rem - 18'h00001;
                    if (rem == 18'h00001) begin
                        next_state = fsvpor_pkg::ST_DONE; // [RULE18]
                    end
                end
            end
            fsvpor_pkg::ST_DONE: begin
                next_cdone = 1'b1; // [RULE1]
                next_info_sel = 1'b0;
                next_state = fsvpor_pkg::ST_IDLE;
            end
            default: begin
                next_state = fsvpor_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= fsvpor_pkg::ST_IDLE;
            cdone <= fsvpor_pkg::RST_DONE;
            aerr <= 1'b0;
            pviol <= 1'b0;
            mg <= fsvpor_pkg::RST_MG;
            launch_idx <= 3'h0;
            fidx <= 3'h0;
            cmd <= 8'h00;
            base <= 24'h000000;
            count <= 16'h0000;
            pdata <= '0;
            cur <= 24'h000000;
            rem <= 18'h00000;
            w <= 2'h0;
            info_sel <= 1'b0;
        end else begin
            state <= next_state;
            cdone <= next_cdone;
            aerr <= next_aerr;
            pviol <= next_pviol;
            mg <= next_mg;
            launch_idx <= next_launch_idx;
            fidx <= next_fidx;
            cmd <= next_cmd;
            base <= next_base;
            count <= next_count;
            pdata <= next_pdata;
            cur <= next_cur;
            rem <= next_rem;
            w <= next_w;
            info_sel <= next_info_sel;
        end
    end
endmodule : fsvpor_seq

/* File: verilog/fsvpor_pkg.sv */
// constants shared by the flash command sequencer and its parameter store
// assumes one system clock; the flash array answers by request/ack
//
// How it works
// [RULE1] clearing complete flag launches; set when finished
// [RULE2] section verify: code 03, address, phrase count
// [RULE3] non-blank section sets both verify bits
// [RULE4] section verify needs index pointer 010
// [RULE5] misaligned phrase address raises access error
// [RULE6] section past flash end raises access error
// [RULE7] address outside valid block raises access error
// [RULE8] command barred in current mode: access error
// [RULE9] verify: any error upper, uncorrectable lower
// [RULE10] once read: code 04, index, returns words
// [RULE11] once field: eight phrases in info region
// [RULE12] fetched phrase stored before complete flag sets
// [RULE13] once read needs index pointer 001
// [RULE14] once read index above seven: access error
// [RULE15] flash reads invalid while once read runs
// [RULE16] software avoids running from the field's block
// [RULE17] program: code 06, address, four data words
// [RULE18] program, read back, then set complete
// [RULE19] program needs index pointer 101
// [RULE20] protected address: violation flag, no programming
// [RULE21] readback error upper bit, uncorrectable lower
// [RULE22] software programs erased phrases only
// [RULE23] software clears error flags before new command
// [RULE24] program refused until clock divider loaded
// [RULE25] phrase is four words, word 0 lowest
package fsvpor_pkg;

    localparam int WORD_W = 16;
    localparam int ADDR_W = 24;
    localparam int NUM_PARAMS = 6;
    localparam int PIDX_W = 3;

    localparam logic [7:0] CMD_SECT_VERIFY = 8'h03;
    localparam logic [7:0] CMD_ONCE_READ = 8'h04;
    localparam logic [7:0] CMD_PHRASE_PGM = 8'h06;

    localparam logic [2:0] IDX_SECT_VERIFY = 3'h2;
    localparam logic [2:0] IDX_ONCE_READ = 3'h1;
    localparam logic [2:0] IDX_PHRASE_PGM = 3'h5;

    // parameter word positions
    localparam logic [2:0] PW_CMD_ADDR_HI = 3'h0;
    localparam logic [2:0] PW_ADDR_LO = 3'h1;
    localparam logic [2:0] PW_COUNT = 3'h2;
    localparam logic [2:0] PW_DATA0 = 3'h2;
    localparam logic [2:0] PW_LAST = 3'h5;

    localparam logic [17:0] PHRASE_WORDS = 18'h00004;
    localparam logic [23:0] WORD_BYTES = 24'h000002;
    localparam logic [23:0] PHRASE_BYTES = 24'h000008;
    localparam logic [15:0] ONCE_MAX_IDX = 16'h0007;
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;

    // program flash window, defaults of the top parameters
    localparam logic [23:0] PF_LO_DEF = 24'hFE0000;
    localparam logic [23:0] PF_HI_DEF = 24'hFFFFFF;

    // bit of mode_permits per command
    localparam int PERMIT_SECT = 0;
    localparam int PERMIT_ONCE = 1;
    localparam int PERMIT_PGM = 2;

    localparam logic RST_DONE = 1'b1;
    localparam logic [1:0] RST_MG = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_CHECK = 3'b011,
        ST_RUN = 3'b010,
        ST_VERIFY = 3'b110,
        ST_DONE = 3'b111
    } fsvpor_state_e;

endpackage : fsvpor_pkg

/* File: verilog/fsvpor_param_mem.sv */
// command parameter word store, one write and one registered read port
// assumes the caller arbitrates the single write port
`timescale 1ns/1ns
module fsvpor_param_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 6,
    parameter int AW = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    always_comb begin
        // unmapped index reads zero
        next_rdata = '0;
        if (32'(raddr) < DEPTH) begin
            next_rdata = mem[raddr];
        end
    end

    always_ff @(posedge clk) begin
        if (we && 32'(waddr) < DEPTH) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule : fsvpor_param_mem

/* File: dv/fsvpor_seq_chk.sv */
// assertion checker for the flash command sequencer, bound to its top
// assumes only the top ports are visible; one clock, async low reset
`timescale 1ns/1ns
module fsvpor_seq_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic launch,
    input wire logic [2:0] mode_permits,
    input wire logic clock_divider_loaded,
    input wire logic command_complete_flag,
    input wire logic access_error_flag,
    input wire logic protection_violation_flag,
    input wire logic [1:0] verify_status_bits,
    input wire logic pflash_read_invalid,
    input wire logic flash_req,
    input wire logic flash_we,
    input wire logic flash_info_sel,
    input wire logic [23:0] flash_addr,
    input wire logic [15:0] flash_wdata,
    input wire logic flash_ack
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    launch_drop_a: assert property (
        launch && command_complete_flag && !access_error_flag &&
        !protection_violation_flag |=>
        !command_complete_flag && verify_status_bits == 2'h0)
        else $error("accepted launch left complete flag or status");
    idle_quiet_a: assert property (
        command_complete_flag |-> !flash_req)
        else $error("flash request while idle");
    err_done_a: assert property (
        $rose(access_error_flag) |->
        !command_complete_flag ##1 command_complete_flag)
        else $error("launch error not followed by completion");
    req_hold_a: assert property (
        flash_req && !flash_ack |=>
        flash_req && $stable(flash_addr) && $stable(flash_wdata))
        else $error("flash request changed before ack");
    wr_step_a: assert property (
        flash_req && flash_ack && flash_we ##1 flash_req && flash_we |->
        flash_addr == $past(flash_addr) + 24'h000002)
        else $error("program word address did not step by two");
    once_busy_a: assert property (
        flash_req && flash_info_sel |-> pflash_read_invalid)
        else $error("flash reads not marked invalid during once read");
    once_field_a: assert property (
        flash_req && flash_info_sel |->
        !flash_we && flash_addr < 24'h000040)
        else $error("once read outside the reserved field");
    prot_no_wr_a: assert property (
        protection_violation_flag |-> !flash_we)
        else $error("programming after protection violation");
    wr_allowed_a: assert property (
        flash_we |-> clock_divider_loaded && mode_permits[2])
        else $error("programming without divider or mode permission");
    phrase_align_a: assert property (
        $rose(flash_req) |-> flash_addr[2:0] == 3'h0)
        else $error("command started on misaligned address");
    vsb_pair_a: assert property (
        verify_status_bits[0] |-> verify_status_bits[1])
        else $error("lower status bit without upper");

    cover property (flash_req && flash_we && flash_ack);
    cover property (flash_req && flash_info_sel && flash_ack);
    cover property ($rose(access_error_flag));
    cover property ($rose(verify_status_bits[0]));
endmodule : fsvpor_seq_chk

bind fsvpor_seq fsvpor_seq_chk u_chk (.*);

/* File: dv/testbench.sv */
// self-checking bench for the flash command sequencer
// bench plays software and the flash array; ack latency alternates 1-2
`timescale 1ns/1ns
module testbench;
    logic clk, nrst, param_wr, launch, access_error_clr;
    logic protection_violation_clr, clock_divider_loaded, prot_en;
    logic flash_ack = 1'b0, flash_rd_err = 1'b0, flash_rd_uncorr = 1'b0;
    logic inj_err, inj_unc;
    logic [2:0] param_index_pointer, mode_permits;
    logic [15:0] param_wdata, param_rdata, flash_wdata;
    logic [15:0] flash_rdata = 16'h0000;
    logic [17:0] prot_lo, prot_hi;
    logic command_complete_flag, access_error_flag, tick = 1'b0;
    logic protection_violation_flag, pflash_read_invalid;
    logic flash_req, flash_we, flash_info_sel;
    logic [1:0] verify_status_bits;
    logic [23:0] flash_addr;
    logic [15:0] mem [logic [23:0]];
    logic [15:0] once_mem [32];
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    fsvpor_seq DUT (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // array model: released read lines show the inverse of the last value
    always @(posedge clk) begin
        tick <= ~tick;
        flash_ack <= 1'b0;
        flash_rdata <= ~flash_rdata;
        flash_rd_err <= ~flash_rd_err;
        flash_rd_uncorr <= ~flash_rd_uncorr;
        if (flash_req && !flash_ack && tick) begin
            flash_ack <= 1'b1;
            flash_rd_err <= inj_err;
            flash_rd_uncorr <= inj_unc;
            if (flash_info_sel)
                flash_rdata <= once_mem[flash_addr[5:1]];
            else if (flash_we)
                mem[flash_addr] = flash_wdata;
            else if (mem.exists(flash_addr))
                flash_rdata <= mem[flash_addr];
            else
                flash_rdata <= 16'hFFFF;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            results();
        end
    end

    task automatic results;
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [2:0] i, input logic [15:0] d);
        @(posedge clk);
        param_index_pointer <= i;
        param_wdata <= d;
        param_wr <= 1'b1;
        @(posedge clk);
        param_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] i, input logic [15:0] e);
        @(posedge clk);
        param_index_pointer <= i;
        repeat (2) @(posedge clk);
        #1 chk("param_rdata", e, param_rdata);
    endtask : rd

    // launch, then wait for the complete flag under a bound
    task automatic go(input logic [2:0] i);
        int n = 0;
        @(posedge clk);
        param_index_pointer <= i;
        launch <= 1'b1;
        @(posedge clk);
        launch <= 1'b0;
        @(posedge clk);
        while (command_complete_flag !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n == 500) chk("completion", 16'h0001, 16'h0000);
    endtask : go

    task automatic cmd(input logic [95:0] ws, input int c, logic [2:0] i);
        for (int k = 0; k < c; k++) wr(3'(k), ws[95-16*k -: 16]);
        go(i);
    endtask : cmd

    task automatic fl(input logic [1:0] e);
        chk("error_flags", {14'h0, e},
            {14'h0, access_error_flag, protection_violation_flag});
    endtask : fl

    task automatic vb(input logic [1:0] e);
        chk("verify_status_bits", {14'h0, e}, {14'h0, verify_status_bits});
    endtask : vb

    task automatic clr;
        @(posedge clk);
        access_error_clr <= 1'b1;
        protection_violation_clr <= 1'b1;
        @(posedge clk);
        access_error_clr <= 1'b0;
        protection_violation_clr <= 1'b0;
    endtask : clr

    // md holds divider-loaded on top of the three mode permits
    task automatic ecase(input logic [47:0] ws, input logic [2:0] i,
                         input logic [3:0] md, input logic [1:0] e);
        mode_permits <= md[2:0];
        clock_divider_loaded <= md[3];
        cmd({ws, 48'h0}, 3, i);
        fl(e);
        clr();
        mode_permits <= 3'h7;
        clock_divider_loaded <= 1'b1;
    endtask : ecase

    initial begin
        nrst = 1'b0;
        {param_wr, launch, access_error_clr, protection_violation_clr} = 0;
        {inj_err, inj_unc} = 2'h0;
        {param_index_pointer, param_wdata} = 19'h00000;
        mode_permits = 3'h7;
        clock_divider_loaded = 1'b1;
        prot_en = 1'b1;
        prot_lo = 18'h20100;
        prot_hi = 18'h201FF;
        for (int k = 0; k < 32; k++) once_mem[k] = 16'hA500 + 16'(k * 3);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        cmd({16'h06FE, 16'h0010, 16'h1111, 16'h2222, 16'h3333, 16'h4444},
            6, 3'h5);
        fl(2'h0);
        vb(2'h0);
        for (int k = 0; k < 4; k++)
            chk("flash_word", 16'(16'h1111 * (k + 1)),
                mem[24'hFE0010 + 24'(2 * k)]);
        cmd({16'h03FE, 16'h0008, 16'h0002, 48'h0}, 3, 3'h2);
        vb(2'h3);
        cmd({16'h03FE, 16'h0100, 16'h0003, 48'h0}, 3, 3'h2);
        vb(2'h0);
        for (int k = 2; k < 4; k++) begin
            inj_err <= 1'b1;
            inj_unc <= k[0];
            cmd({16'h03FE, 16'h0100, 16'h0003, 48'h0}, 3, 3'h2);
            vb(2'(k));
            cmd({16'h06FE, 16'h0200 + 16'(8 * k), 64'h5}, 6, 3'h5);
            vb(2'(k));
        end
        inj_err <= 1'b0;
        inj_unc <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            cmd({16'h0400, 16'(k), 64'h0}, 2, 3'h1);
            for (int j = 0; j < 4; j++)
                rd(3'(j + 2), once_mem[4 * k + j]);
        end
        ecase({16'h03FE, 16'h0100, 16'h0001}, 3'h1, 4'hF, 2'h2);
        ecase({16'h03FE, 16'h0102, 16'h0001}, 3'h2, 4'hF, 2'h2);
        ecase({16'h03FF, 16'hFFF8, 16'h0002}, 3'h2, 4'hF, 2'h2);
        ecase({16'h0300, 16'h0100, 16'h0001}, 3'h2, 4'hF, 2'h2);
        ecase({16'h03FE, 16'h0100, 16'h0001}, 3'h2, 4'hE, 2'h2);
        ecase({16'h03FE, 16'h0100, 16'h0000}, 3'h2, 4'hF, 2'h2);
        ecase({16'h0400, 16'h0001, 16'h0000}, 3'h5, 4'hF, 2'h2);
        ecase({16'h0400, 16'h0008, 16'h0000}, 3'h1, 4'hF, 2'h2);
        ecase({16'h0400, 16'h0001, 16'h0000}, 3'h1, 4'hD, 2'h2);
        ecase({16'h06FE, 16'h0304, 16'h0000}, 3'h5, 4'hF, 2'h2);
        ecase({16'h0600, 16'h0300, 16'h0000}, 3'h5, 4'hF, 2'h2);
        ecase({16'h06FE, 16'h0300, 16'h0000}, 3'h5, 4'hB, 2'h2);
        ecase({16'h06FE, 16'h0300, 16'h0000}, 3'h5, 4'h7, 2'h2);
        ecase({16'h06FE, 16'h0100, 16'h0000}, 3'h5, 4'hF, 2'h1);
        chk("protected_write", 16'h0,
            {15'h0, 1'(mem.exists(24'hFE0100))});
        // pending error must swallow an otherwise valid launch
        cmd({16'h06FE, 16'h0300, 64'h7}, 6, 3'h2);
        go(3'h5);
        fl(2'h2);
        chk("refused_write", 16'h0,
            {15'h0, 1'(mem.exists(24'hFE0300))});
        clr();
        results();
    end
endmodule : testbench
